/* File: core/ryr_pkg.sv */
// Register map and field constants for the year and alarm register block
package ryr_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;

	// Register indices; the byte address is four times the index
	localparam logic [11:0] IDX_YEAR      = 12'hF36;
	localparam logic [11:0] IDX_ALARM_SEC = 12'hF37;
	localparam logic [11:0] IDX_ALARM_MIN = 12'hF38;
	localparam logic [11:0] IDX_AHRS      = 12'hF39;
	localparam logic [11:0] IDX_ADOM      = 12'hF3A;
	localparam logic [11:0] IDX_CTRL      = 12'hF3C;
	localparam logic [11:0] IDX_STAT      = 12'hF3D;

	localparam logic [ADDR_W-1:0] ADDR_YEAR      = {2'h0, IDX_YEAR, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ALARM_SEC = {2'h0, IDX_ALARM_SEC, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ALARM_MIN = {2'h0, IDX_ALARM_MIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_AHRS      = {2'h0, IDX_AHRS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ADOM      = {2'h0, IDX_ADOM, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL      = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STAT      = {2'h0, IDX_STAT, 2'h0};

	// Control register fields
	localparam int unsigned CTRL_BCD_BIT  = 0;
	localparam int unsigned CTRL_MODE_BIT = 1;
	localparam int unsigned CTRL_LOCK_BIT = 2;
	localparam int unsigned CTRL_W        = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

	// Status register fields
	localparam int unsigned STAT_MATCH_BIT = 0;

	// Field layouts
	localparam logic [7:0] CAL_BCD_MASK  = 8'h7F;
	localparam logic [7:0] CAL_BIN_MASK  = 8'h3F;
	localparam logic [7:0] YEAR_BIN_MASK = 8'h7F;
	localparam logic [6:0] YEAR_BIN_MAX  = 7'h63;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/ryr_year_step.sv */
// Next year value for one year tick, in BCD or binary layout
`timescale 1ns/100ps
module ryr_year_step
	import ryr_pkg::*;
(
	// Current value and layout
	input  wire logic [7:0] i_year,
	input  wire logic       i_bcd_en,
	// Incremented value
	output logic      [7:0] o_year_next
);
	always_comb begin
		if (i_bcd_en) begin
			if (i_year[3:0] >= BCD_DIGIT_MAX) begin
				o_year_next[3:0] = 4'h0;
				if (i_year[7:4] >= BCD_DIGIT_MAX)
					o_year_next[7:4] = 4'h0;
				else
					o_year_next[7:4] = i_year[7:4] + 4'h1;
			end else begin
				o_year_next[3:0] = i_year[3:0] + 4'h1;
				o_year_next[7:4] = i_year[7:4];
			end
		end else begin
			// Reserved top bit is forced low in binary layout
			o_year_next[7] = 1'b0;
			if (i_year[6:0] >= YEAR_BIN_MAX)
				o_year_next[6:0] = 7'h00;
			else
				o_year_next[6:0] = i_year[6:0] + 7'h01;
		end
	end
endmodule // ryr_year_step

/* File: core/ryr_regs.sv */
// Year and alarm registers with AXI4-Lite access and alarm compare
`timescale 1ns/100ps
module ryr_regs
	import ryr_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] i_axi_awaddr,
	input  wire logic              i_axi_awvalid,
	output logic                   o_axi_awready,
	input  wire logic [DATA_W-1:0] i_axi_wdata,
	input  wire logic [3:0]        i_axi_wstrb,
	input  wire logic              i_axi_wvalid,
	output logic                   o_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             o_axi_bresp,
	output logic                   o_axi_bvalid,
	input  wire logic              i_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] i_axi_araddr,
	input  wire logic              i_axi_arvalid,
	output logic                   o_axi_arready,
	output logic [DATA_W-1:0]      o_axi_rdata,
	output logic [1:0]             o_axi_rresp,
	output logic                   o_axi_rvalid,
	input  wire logic              i_axi_rready,
	// Running time from the clock chain
	input  wire logic              i_year_tick,
	input  wire logic [7:0]        i_time_sec,
	input  wire logic [7:0]        i_time_min,
	input  wire logic [31:0]       i_counter,
	// Status outputs
	output logic                   o_alarm_event,
	output logic                   o_bcd_en,
	output logic                   o_counter_mode,
	output logic                   o_locked
);
	// Bus state
	logic              aw_held, next_aw_held;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic              w_held, next_w_held;
	logic [7:0]        w_byte, next_w_byte;
	logic              w_lane0, next_w_lane0;
	logic              awready, next_awready;
	logic              wready, next_wready;
	logic              bvalid, next_bvalid;
	logic [1:0]        bresp, next_bresp;
	logic              arready, next_arready;
	logic              rvalid, next_rvalid;
	logic [7:0]        rbyte, next_rbyte;
	logic [1:0]        rresp, next_rresp;
	logic              wr_fire;
	logic              wr_hit;
	logic              rd_hit;
	logic [7:0]        rd_val;

	// Register contents; data registers are not reset
	logic [CTRL_W-1:0] ctrl, next_ctrl;
	logic [7:0]        year, next_year;
	logic [7:0]        alarm_seconds, next_alarm_seconds;
	logic [7:0]        alarm_minutes, next_alarm_minutes;
	logic [7:0]        ahrs, next_ahrs;
	logic [7:0]        adom, next_adom;
	logic [7:0]        year_inc;
	logic              year_wr;

	// Alarm compare state
	logic              match_now;
	logic              match_q, next_match_q;
	logic              event_q, next_event_q;
	logic [7:0]        cal_mask;

	ryr_year_step u_year_step (
		.i_year      (year),
		.i_bcd_en    (ctrl[CTRL_BCD_BIT]),
		.o_year_next (year_inc)
	);

	// Write channel: address and data are taken in either order
	assign wr_fire = aw_held && w_held;

	always_comb begin
		wr_hit = 1'b1;
		unique case (aw_addr)
			ADDR_YEAR, ADDR_ALARM_SEC, ADDR_ALARM_MIN, ADDR_AHRS,
			ADDR_ADOM, ADDR_CTRL, ADDR_STAT: wr_hit = 1'b1;
			default:                         wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (i_axi_awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = i_axi_awaddr;
		end
		if (i_axi_wvalid && wready) begin
			next_w_held  = 1'b1;
			next_w_byte  = i_axi_wdata[7:0];
			next_w_lane0 = i_axi_wstrb[0];
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && i_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	// Read channel: one cycle from address to data
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		unique case (i_axi_araddr)
			ADDR_YEAR:      rd_val = year;
			ADDR_ALARM_SEC: rd_val = alarm_seconds;
			ADDR_ALARM_MIN: rd_val = alarm_minutes;
			ADDR_AHRS:      rd_val = ahrs;
			ADDR_ADOM:      rd_val = adom;
			ADDR_CTRL:      rd_val = {{(8-CTRL_W){1'b0}}, ctrl};
			ADDR_STAT:      rd_val = {7'h00, match_q};
			default:        rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		next_rvalid = rvalid;
		next_rbyte  = rbyte;
		next_rresp  = rresp;
		if (i_axi_arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rbyte  = rd_val;
			next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && i_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rbyte   <= 8'h00;
			rresp   <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held  <= next_w_held;
			w_byte  <= next_w_byte;
			w_lane0 <= next_w_lane0;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rbyte   <= next_rbyte;
			rresp   <= next_rresp;
		end
	end

	// Register updates; a software write to year beats the tick
	assign year_wr = wr_fire && w_lane0 && (aw_addr == ADDR_YEAR)
		&& !ctrl[CTRL_LOCK_BIT];

	always_comb begin
		next_ctrl = ctrl;
		next_year = year;
		next_alarm_seconds = alarm_seconds;
		next_alarm_minutes = alarm_minutes;
		next_ahrs = ahrs;
		next_adom = adom;
		if (year_wr)
			next_year = w_byte;
		else if (i_year_tick)
			next_year = year_inc;
		if (wr_fire && w_lane0) begin
			unique case (aw_addr)
				ADDR_ALARM_SEC: next_alarm_seconds = w_byte;
				ADDR_ALARM_MIN: next_alarm_minutes = w_byte;
				ADDR_AHRS:      next_ahrs = w_byte;
				ADDR_ADOM:      next_adom = w_byte;
				ADDR_CTRL:      next_ctrl = w_byte[CTRL_W-1:0];
				default:        next_ctrl = ctrl;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst)
			ctrl <= CTRL_RST;
		else
			ctrl <= next_ctrl;
	end

	// No reset: contents survive reset, undefined after power-up
	always_ff @(posedge i_clk) begin
		year <= next_year;
		alarm_seconds <= next_alarm_seconds;
		alarm_minutes <= next_alarm_minutes;
		ahrs <= next_ahrs;
		adom <= next_adom;
	end

	// Alarm compare
	always_comb begin
		cal_mask = ctrl[CTRL_BCD_BIT] ? CAL_BCD_MASK
			: CAL_BIN_MASK;
		if (ctrl[CTRL_MODE_BIT])
			match_now = (i_counter
				== {alarm_seconds, alarm_minutes, ahrs, adom});
		else
			match_now = (((alarm_seconds ^ i_time_sec) & cal_mask) == 8'h00)
				&& (((alarm_minutes ^ i_time_min) & cal_mask) == 8'h00);
		next_match_q = match_now;
		next_event_q = match_now && !match_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			match_q <= 1'b0;
			event_q <= 1'b0;
		end else begin
			match_q <= next_match_q;
			event_q <= next_event_q;
		end
	end

	assign o_axi_awready  = awready;
	assign o_axi_wready   = wready;
	assign o_axi_bresp    = bresp;
	assign o_axi_bvalid   = bvalid;
	assign o_axi_arready  = arready;
	assign o_axi_rdata    = {24'h000000, rbyte};
	assign o_axi_rresp    = rresp;
	assign o_axi_rvalid   = rvalid;
	assign o_alarm_event  = event_q;
	assign o_bcd_en       = ctrl[CTRL_BCD_BIT];
	assign o_counter_mode = ctrl[CTRL_MODE_BIT];
	assign o_locked       = ctrl[CTRL_LOCK_BIT];

	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	a_year_lock_hold: assert property (
		wr_fire && w_lane0 && aw_addr == ADDR_YEAR && ctrl[CTRL_LOCK_BIT]
		&& !i_year_tick |=> year == $past(year))
		else $error("year changed by a write while locked");
	a_year_open_write: assert property (
		year_wr |=> year == $past(w_byte))
		else $error("unlocked year write not stored");
	a_year_bcd_tens: assert property (
		i_year_tick && !year_wr && ctrl[CTRL_BCD_BIT] && year == 8'h19
		|=> year == 8'h20)
		else $error("bcd year tens carry wrong");
	a_year_bcd_wrap: assert property (
		i_year_tick && !year_wr && ctrl[CTRL_BCD_BIT] && year == 8'h99
		|=> year == 8'h00)
		else $error("bcd year did not wrap");
	a_year_bin_wrap: assert property (
		i_year_tick && !year_wr && !ctrl[CTRL_BCD_BIT] && year == 8'h63
		|=> year == 8'h00)
		else $error("binary year did not wrap at 99");
	a_alarm_sec_write: assert property (
		wr_fire && w_lane0 && aw_addr == ADDR_ALARM_SEC
		|=> alarm_seconds == $past(w_byte) && bvalid)
		else $error("alarm seconds write lost");
	a_alarm_min_write: assert property (
		wr_fire && w_lane0 && aw_addr == ADDR_ALARM_MIN
		|=> alarm_minutes == $past(w_byte) && bvalid)
		else $error("alarm minutes write lost");
	a_counter_match: assert property (
		ctrl[CTRL_MODE_BIT] && i_counter
		== {alarm_seconds, alarm_minutes, ahrs, adom} |=> match_q)
		else $error("counter alarm match missed");
	a_cal_bcd_match: assert property (
		!ctrl[CTRL_MODE_BIT] && ctrl[CTRL_BCD_BIT]
		&& alarm_seconds[6:0] == i_time_sec[6:0]
		&& alarm_minutes[6:0] == i_time_min[6:0] |=> match_q)
		else $error("bcd calendar alarm match missed");
	a_cal_bin_match: assert property (
		!ctrl[CTRL_MODE_BIT] && !ctrl[CTRL_BCD_BIT]
		&& alarm_seconds[5:0] == i_time_sec[5:0]
		&& alarm_minutes[5:0] == i_time_min[5:0] |=> match_q)
		else $error("binary calendar alarm match missed");
	a_alarm_one_pulse: assert property (
		o_alarm_event |-> $past(match_now) && !$past(match_q)
		##1 !o_alarm_event)
		else $error("alarm event not a single rising pulse");

	c_year_write: cover property (year_wr ##1 bvalid);
	c_counter_alarm: cover property (ctrl[CTRL_MODE_BIT] && event_q);
	c_bcd_wrap: cover property (i_year_tick && year == 8'h99);
	c_read_done: cover property (rvalid && i_axi_rready);
endmodule // ryr_regs

/* File: tb/testbench.sv */
// Self-checking bench for the year and alarm register block
`timescale 1ns/100ps
module testbench;
	import ryr_pkg::*;

	logic        i_clk = 1'b0;
	logic        i_srst = 1'b1;
	logic [15:0] awaddr = 16'h0;
	logic [15:0] araddr = 16'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] cnt = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        tick = 1'b0;
	logic [7:0]  tsec = 8'h0;
	logic [7:0]  tmin = 8'h0;
	wire logic        awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic        alarm_event, bcd_en, counter_mode, locked;
	int          err_total = 0;
	int          n_tests = 0;

	always #10 i_clk = ~i_clk;

	ryr_regs i_dut (
		.i_clk(i_clk), .i_srst(i_srst),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
		.o_axi_awready(awready), .i_axi_wdata(wdata),
		.i_axi_wstrb(4'hF), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
		.o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
		.i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
		.o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
		.o_axi_rvalid(rvalid), .i_axi_rready(rready),
		.i_year_tick(tick), .i_time_sec(tsec), .i_time_min(tmin),
		.i_counter(cnt), .o_alarm_event(alarm_event), .o_bcd_en(bcd_en),
		.o_counter_mode(counter_mode), .o_locked(locked)
	);

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t ns: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// Cut a hung handshake short
	task automatic tmo(input int n);
		if (n >= 40) begin
			err_total++;
			$display("handshake wait ran out at %0t ns", $time);
			results;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] exp_resp);
		int   n;
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !(aw_ok && w_ok); n++) begin
			@(posedge i_clk);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		tmo(n);
		for (n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (bvalid === 1'b1)
				break;
		end
		tmo(n);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, exp_resp});
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp,
		input logic [1:0] exp_resp);
		int n;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		tmo(n);
		rready <= 1'b0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, exp_resp});
	endtask

	// Present running time, then count alarm pulses
	task automatic ev(input logic [7:0] s, input logic [7:0] m,
		input logic [31:0] c, input int exp_n);
		int n;
		int k;
		k = 0;
		@(posedge i_clk);
		tsec <= s;
		tmin <= m;
		cnt <= c;
		for (n = 0; n < 5; n++) begin
			@(posedge i_clk);
			if (alarm_event === 1'b1)
				k++;
		end
		chk(32'(k), 32'(exp_n));
	endtask

	task automatic year_tick(input logic [7:0] exp);
		@(posedge i_clk);
		tick <= 1'b1;
		@(posedge i_clk);
		tick <= 1'b0;
		rd(ADDR_YEAR, {24'h0, exp}, RESP_OKAY);
	endtask

	task automatic t_lock;
		rd(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_YEAR, 8'h42, RESP_OKAY);
		rd(ADDR_YEAR, 32'h42, RESP_OKAY);
		wr(ADDR_CTRL, 8'h04, RESP_OKAY);
		chk({31'h0, locked}, 32'h1);
		wr(ADDR_YEAR, 8'h17, RESP_OKAY);
		rd(ADDR_YEAR, 32'h42, RESP_OKAY);
		wr(ADDR_ALARM_SEC, 8'h3B, RESP_OKAY);
		rd(ADDR_ALARM_SEC, 32'h3B, RESP_OKAY);
		wr(ADDR_ALARM_MIN, 8'h2A, RESP_OKAY);
		rd(ADDR_ALARM_MIN, 32'h2A, RESP_OKAY);
		wr(ADDR_CTRL, 8'h00, RESP_OKAY);
		chk({31'h0, locked}, 32'h0);
		wr(ADDR_YEAR, 8'h17, RESP_OKAY);
		@(posedge i_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		rd(ADDR_YEAR, 32'h17, RESP_OKAY);
		rd(ADDR_ALARM_SEC, 32'h3B, RESP_OKAY);
		rd(ADDR_ALARM_MIN, 32'h2A, RESP_OKAY);
		$display("test lock and reset done");
	endtask

	task automatic t_tick;
		wr(ADDR_YEAR, 8'h62, RESP_OKAY);
		year_tick(8'h63);
		year_tick(8'h00);
		wr(ADDR_CTRL, 8'h01, RESP_OKAY);
		chk({31'h0, bcd_en}, 32'h1);
		wr(ADDR_YEAR, 8'h18, RESP_OKAY);
		year_tick(8'h19);
		year_tick(8'h20);
		wr(ADDR_YEAR, 8'h99, RESP_OKAY);
		year_tick(8'h00);
		$display("test year count done");
	endtask

	task automatic t_cal;
		wr(ADDR_CTRL, 8'h00, RESP_OKAY);
		wr(ADDR_ALARM_SEC, 8'h3B, RESP_OKAY);
		wr(ADDR_ALARM_MIN, 8'h2A, RESP_OKAY);
		ev(8'h3A, 8'h2A, 32'h0, 0);
		ev(8'h3B, 8'h2A, 32'h0, 1);
		ev(8'h3B, 8'h2B, 32'h0, 0);
		ev(8'h3B, 8'h2A, 32'h0, 1);
		wr(ADDR_CTRL, 8'h01, RESP_OKAY);
		wr(ADDR_ALARM_SEC, 8'h59, RESP_OKAY);
		wr(ADDR_ALARM_MIN, 8'h45, RESP_OKAY);
		ev(8'h58, 8'h45, 32'h0, 0);
		ev(8'h59, 8'h45, 32'h0, 1);
		ev(8'h59, 8'h35, 32'h0, 0);
		ev(8'h59, 8'h45, 32'h0, 1);
		$display("test calendar alarm done");
	endtask

	task automatic t_cnt;
		wr(ADDR_AHRS, 8'hC3, RESP_OKAY);
		wr(ADDR_ADOM, 8'h3C, RESP_OKAY);
		wr(ADDR_ALARM_SEC, 8'hA5, RESP_OKAY);
		wr(ADDR_ALARM_MIN, 8'h5A, RESP_OKAY);
		wr(ADDR_CTRL, 8'h02, RESP_OKAY);
		chk({31'h0, counter_mode}, 32'h1);
		ev(8'h0, 8'h0, 32'hA55AC33D, 0);
		ev(8'h0, 8'h0, 32'hA55AC33C, 1);
		ev(8'h0, 8'h0, 32'hA55BC33C, 0);
		ev(8'h0, 8'h0, 32'hA55AC23C, 0);
		wr(ADDR_CTRL, 8'h03, RESP_OKAY);
		ev(8'h0, 8'h0, 32'hA45AC33C, 0);
		ev(8'h0, 8'h0, 32'hA55AC33C, 1);
		$display("test counter alarm done");
	endtask

	task automatic t_bad;
		wr(16'h3FFC, 8'h11, RESP_SLVERR);
		rd(16'h3FFC, 32'h0, RESP_SLVERR);
		wr(ADDR_YEAR + 16'h1, 8'h11, RESP_SLVERR);
		rd(ADDR_YEAR, 32'h00, RESP_OKAY);
		$display("test unmapped access done");
	endtask

	initial begin
		repeat (8) @(posedge i_clk);
		i_srst <= 1'b0;
		t_lock;
		t_tick;
		t_cal;
		t_cnt;
		t_bad;
		results;
	end
endmodule // testbench
